// ==== asrc_pkg.sv ====
// Package for the asynchronous static memory host controller.
// Assumes a single 10 MHz clock; the power and read cycle counts derive from it, the retention count is fixed at one.
package asrc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 20; // One mebiword of locations
  localparam int DATA_W = 16; // Two byte lanes per word

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100; // 10 MHz clock
  localparam int POWER_WAIT_US = 100; // Supply-good to first access
  localparam int POWER_WAIT_CYC =
    (POWER_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYCLE_TIME_NS = 10; // Least read cycle time
  localparam int READ_CYCLE_CYC_RAW =
    (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYCLE_CYC =
    (READ_CYCLE_CYC_RAW < 1) ? 1 : READ_CYCLE_CYC_RAW;
  localparam int DESELECT_TO_RETENTION_TIME_NS = 0; // Least time
  localparam int DESELECT_TO_RETENTION_CYC = 1; // Never below one cycle
  localparam int CNT_W = 10; // Wide enough for every wait count
  localparam logic [CNT_W-1:0] POWER_WAIT_CNT = CNT_W'(POWER_WAIT_CYC);
  localparam logic [CNT_W-1:0] RECOVER_CNT = CNT_W'(READ_CYCLE_CYC);
  localparam logic [CNT_W-1:0] RETENTION_CNT =
    CNT_W'(DESELECT_TO_RETENTION_CYC);

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Pin set driven toward the memory
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic chip_select_n;
    logic output_enable_n;
    logic write_enable_n;
    logic low_lane_enable_n;
    logic high_lane_enable_n;
  } asrc_pins_type;

  // Request from the user side
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] lane_en; // Bit 0 low lane, bit 1 high lane
  } asrc_req_type;

  localparam asrc_pins_type PINS_IDLE = '{
    addr: '0, chip_select_n: 1'b1, output_enable_n: 1'b1,
    write_enable_n: 1'b1, low_lane_enable_n: 1'b1,
    high_lane_enable_n: 1'b1};

endpackage

// ==== asrc_wait.sv ====
// Down counter used for every wait in the controller.
// Assumes a synchronous active-low reset copy from the top.
`timescale 1ns/10ps
module asrc_wait
  import asrc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic [asrc_pkg::CNT_W-1:0] value,
  // Status
  output logic done
);
  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] count; // Cycles still to wait
  logic [CNT_W-1:0] next_count;

  // Load wins over counting, so a new wait restarts cleanly
  always_comb begin
    if (load) begin
      next_count = value;
    end else if (count != '0) begin
      next_count = count - CNT_W'(1);
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // Leave reset armed with the power wait, so a supply that is
      // good from the start still waits before the first access
      count <= POWER_WAIT_CNT;
    end else begin
      count <= next_count;
    end
  end

  assign done = (count == '0) && !load;
endmodule

// ==== asrc_host.sv ====
// Host controller driving an asynchronous 1M x 16 static memory.
// Assumes the supply-good and retention controls arrive synchronous
// to clock, and that the board resolves the shared data bus.
//
// Summary of operation
// - Write: select and write strobe low, lanes chosen
// - Read: select and output enable low, strobe high
// - Write ends on first released strobe; hold data
// - Wait 100 us after supply good first
// - Deselect before retention; wait read cycle after
`timescale 1ns/10ps
module asrc_host
  import asrc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Power sequencing
  input wire logic supply_good,
  input wire logic retention_req,
  output logic retention_ready,
  // User request
  input wire logic req_valid,
  input wire asrc_pkg::asrc_req_type req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [asrc_pkg::DATA_W-1:0] rsp_data,
  // Memory pins
  output asrc_pkg::asrc_pins_type pins,
  input wire logic [asrc_pkg::DATA_W-1:0] data_in,
  output logic [asrc_pkg::DATA_W-1:0] data_out,
  output logic data_oe
);
  import asrc_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta; // First stage, read only by second
  logic rst_n; // Released copy used everywhere

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // State and wait counter
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWER, ST_IDLE, ST_READ, ST_WRITE, ST_WEND, ST_RETAIN,
    ST_RECOVER
  } asrc_state_type;

  asrc_state_type state; // Sequencer state
  asrc_state_type next_state;
  logic wait_load; // Start a wait
  logic [CNT_W-1:0] wait_value; // Length of that wait
  logic wait_done; // Wait has expired

  asrc_wait u_wait (
    .clock(clock),
    .rst_n(rst_n),
    .load(wait_load),
    .value(wait_value),
    .done(wait_done)
  );

  // Lane enables in pin polarity from the request mask
  function automatic logic [1:0] lanes_n(input logic [1:0] en);
    lanes_n = ~en;
  endfunction

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  asrc_pins_type next_pins;
  logic [DATA_W-1:0] next_data_out;
  logic next_data_oe;
  logic next_req_ready;
  logic next_rsp_valid;
  logic [DATA_W-1:0] next_rsp_data;
  logic next_retention_ready;

  // Next-state and next-pin logic
  always_comb begin
    next_state = state;
    next_pins = pins;
    next_data_out = data_out;
    next_data_oe = data_oe;
    next_req_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_retention_ready = retention_ready;
    wait_load = 1'b0;
    wait_value = POWER_WAIT_CNT;
    case (state)
      ST_POWER: begin
        // Hold off all access until supply settled long enough
        next_pins = PINS_IDLE;
        if (!supply_good) begin
          wait_load = 1'b1;
        end else if (wait_done) begin
          next_state = ST_IDLE;
          next_req_ready = 1'b1;
        end
      end
      ST_IDLE: begin
        // Deselected: memory sits in standby here
        next_pins = PINS_IDLE;
        next_data_oe = 1'b0;
        next_req_ready = 1'b1;
        if (!supply_good) begin
          next_state = ST_POWER;
          next_req_ready = 1'b0;
          // Restart the full wait; a short dip must not skip it
          wait_load = 1'b1;
        end else if (retention_req) begin
          // Select is already high
          next_state = ST_RETAIN;
          next_req_ready = 1'b0;
          wait_load = 1'b1;
          wait_value = RETENTION_CNT;
        end else if (req_valid && req_ready) begin
          next_req_ready = 1'b0;
          next_pins.addr = req.addr;
          next_pins.chip_select_n = 1'b0;
          {next_pins.high_lane_enable_n,
           next_pins.low_lane_enable_n} = lanes_n(req.lane_en);
          if (req.write) begin
            // Drive data with the strobe; memory floats
            next_pins.write_enable_n = 1'b0;
            next_data_out = req.wdata;
            next_data_oe = 1'b1;
            next_state = ST_WRITE;
          end else begin
            // Strobe stays high while reading
            next_pins.output_enable_n = 1'b0;
            next_state = ST_READ;
          end
        end
      end
      ST_READ: begin
        // One 100 ns cycle covers the access time; sample data
        next_rsp_data = data_in;
        next_rsp_valid = 1'b1;
        next_pins = PINS_IDLE;
        next_state = ST_IDLE;
      end
      ST_WRITE: begin
        // Release strobe first; data held past that edge
        next_pins.write_enable_n = 1'b1;
        next_state = ST_WEND;
      end
      ST_WEND: begin
        // Only now deselect and stop driving data
        next_pins = PINS_IDLE;
        next_data_oe = 1'b0;
        next_rsp_valid = 1'b1;
        next_state = ST_IDLE;
      end
      ST_RETAIN: begin
        // Stay deselected while the supply is lowered
        next_pins = PINS_IDLE;
        if (wait_done) begin
          next_retention_ready = 1'b1;
        end
        if (!retention_req) begin
          next_retention_ready = 1'b0;
          next_state = ST_RECOVER;
          wait_load = 1'b1;
          wait_value = RECOVER_CNT;
        end
      end
      ST_RECOVER: begin
        // One read cycle time before the next access
        next_pins = PINS_IDLE;
        if (wait_done) begin
          next_state = ST_IDLE;
          next_req_ready = 1'b1;
        end
      end
      default: begin
        next_state = ST_POWER;
        next_pins = PINS_IDLE;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_POWER;
      pins <= PINS_IDLE;
      data_out <= '0;
      data_oe <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      retention_ready <= 1'b0;
    end else begin
      state <= next_state;
      pins <= next_pins;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      retention_ready <= next_retention_ready;
    end
  end
endmodule

// ==== asrc_host_monitor.sv ====
// Checker for the static memory host controller ports.
// Assumes it is bound to asrc_host and sees only its ports.
`timescale 1ns/10ps
module asrc_host_monitor
  import asrc_pkg::*;
(
  // Clock, reset, power
  input wire logic clock,
  input wire logic arst_n,
  input wire logic supply_good,
  input wire logic retention_req,
  input wire logic retention_ready,
  // User side
  input wire logic req_valid,
  input wire asrc_pkg::asrc_req_type req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [asrc_pkg::DATA_W-1:0] rsp_data,
  // Memory side
  input wire asrc_pkg::asrc_pins_type pins,
  input wire logic [asrc_pkg::DATA_W-1:0] data_in,
  input wire logic [asrc_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe
);
  wire cs = pins.chip_select_n; // Short aliases, active low
  wire oe = pins.output_enable_n;
  wire we = pins.write_enable_n;
  wire tk = req_valid && req_ready && supply_good && !retention_req;
  logic [15:0] pw, next_pw; // Cycles of good supply, saturating
  // Saturate so a long run never wraps below the wait
  always_comb next_pw = supply_good ? pw + 16'(pw != 16'hffff) : '0;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) pw <= '0;
    else pw <= next_pw;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  rd_pins_a: assert property (tk && !req.write |=>
    !cs && !oe && we && pins.addr == $past(req.addr)) else $error("rd pins");
  rd_data_a: assert property (tk && !req.write |-> ##2
    rsp_valid && rsp_data == $past(data_in)) else $error("rd data");
  wr_pins_a: assert property (tk && req.write |=> !cs && !we &&
    data_oe && data_out == $past(req.wdata) && {pins.high_lane_enable_n,
    pins.low_lane_enable_n} == ~$past(req.lane_en)) else $error("wr pins");
  wr_end_a: assert property (tk && req.write |-> ##2 we && !cs &&
    data_oe && $stable(data_out) ##1 cs && !data_oe && rsp_valid)
    else $error("wr end");
  no_fight_a: assert property (!oe |-> !data_oe)
    else $error("bus fight");
  rd_strobe_a: assert property (!cs && !oe |-> we)
    else $error("oe with we");
  idle_pins_a: assert property (cs |-> we && oe && !data_oe)
    else $error("idle pins");
  pw_wait_a: assert property (req_ready |->
    pw >= 16'(POWER_WAIT_CYC)) else $error("early access");
  ret_desel_a: assert property (retention_ready |->
    cs && $past(cs)) else $error("retention selected");
  // Ready must stay low for the whole recovery, not just one edge
  recover_a: assert property ($fell(retention_ready) |->
    !req_ready [*2]) else $error("no recovery");
endmodule
bind asrc_host asrc_host_monitor mon_u (.clock, .arst_n, .supply_good,
  .retention_req, .retention_ready, .req_valid, .req, .req_ready,
  .rsp_valid, .rsp_data, .pins, .data_in, .data_out, .data_oe);

// ==== asrc_sram_model.sv ====
// Behavioural 1M x 16 static memory facing the host pins.
// Assumes one host on the bus; resolves the shared data wire.
`timescale 1ns/10ps
module asrc_sram_model
  import asrc_pkg::*;
(
  // Pattern clock for a floating bus
  input wire logic clock,
  // Host pins
  input wire asrc_pkg::asrc_pins_type pins,
  input wire logic [asrc_pkg::DATA_W-1:0] host_d,
  input wire logic host_oe,
  output logic [asrc_pkg::DATA_W-1:0] bus
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] rd, junk = 16'h3c5a; // Junk stands for a float
  logic wr;
  // Undriven bus changes each cycle so stale data never matches
  always @(posedge clock) junk <= ~junk ^ 16'h0101;
  assign wr = !pins.chip_select_n && !pins.write_enable_n;
  // Store while the overlap lasts; the last value at its end stays
  always @(pins or host_d or wr) begin
    if (wr && !mem.exists(pins.addr)) mem[pins.addr] = '0;
    if (wr && !pins.low_lane_enable_n) mem[pins.addr][7:0] = host_d[7:0];
    if (wr && !pins.high_lane_enable_n) mem[pins.addr][15:8] = host_d[15:8];
  end
  // Drive only selected, enabled lanes of a read; else float
  always @(pins or junk) begin
    rd = junk;
    if (!pins.chip_select_n && !pins.output_enable_n && pins.write_enable_n
        && mem.exists(pins.addr)) begin
      if (!pins.low_lane_enable_n) rd[7:0] = mem[pins.addr][7:0];
      if (!pins.high_lane_enable_n) rd[15:8] = mem[pins.addr][15:8];
    end
  end
  assign bus = host_oe ? host_d : rd;
endmodule

// ==== test_asrc_host.sv ====
// Testbench for the static memory host controller.
// Assumes the monitor is bound and the memory model is present.
`timescale 1ns/10ps
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin \
  n_fail++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module test_asrc_host;
  import asrc_pkg::*;
  logic clock, arst_n = 0, supply_good = 0, retention_req = 0;
  logic req_valid = 0, retention_ready, req_ready, rsp_valid, data_oe;
  asrc_req_type req = '0;
  asrc_pins_type pins;
  logic [DATA_W-1:0] rsp_data, data_in, data_out, m, ex [logic [19:0]];
  logic [ADDR_W-1:0] at [8]; // Small address pool, both ends included
  logic [31:0] seed = 32'h6748;
  int n_fail = 0, check_count = 0, i, k;
  asrc_host dut_u (.clock, .arst_n, .supply_good, .retention_req,
    .retention_ready, .req_valid, .req, .req_ready, .rsp_valid,
    .rsp_data, .pins, .data_in, .data_out, .data_oe);
  asrc_sram_model mdl_u (.clock, .pins, .host_d(data_out),
    .host_oe(data_oe), .bus(data_in));
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // One request; waits for ready and answer under a bound
  task op(input logic w, input logic [19:0] a, input logic [15:0] d,
      input logic [1:0] l);
    m = {{8{l[1]}}, {8{l[0]}}};
    for (k = 0; req_ready !== 1'b1 && k < 2000; k++) @(negedge clock);
    req = '{w, a, d, l};
    req_valid = 1;
    @(negedge clock);
    req_valid = 0;
    for (k = 0; rsp_valid !== 1'b1 && k < 10; k++) @(negedge clock);
    `CHK("rsp_valid", 1'b1, rsp_valid)
    if (w) ex[a] = (ex[a] & ~m) | (d & m);
    else `CHK("rsp_data", ex[a] & m, rsp_data & m)
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    n_fail++;
    results;
  end
  initial begin
    repeat (6) @(negedge clock);
    arst_n = 1;
    repeat (20) @(negedge clock);
    `CHK("ready_no_supply", 1'b0, req_ready)
    supply_good = 1;
    for (k = 0; req_ready !== 1'b1 && k < 1100; k++) @(negedge clock);
    `CHK("power_wait", 1'b1, k >= POWER_WAIT_CYC && k < 1100)
    $display("power wait test done");
    for (i = 0; i < 8; i++) at[i] = i == 0 ? '0 : i == 1 ? '1 : xs();
    for (i = 0; i < 8; i++) op(1, at[i], xs(), 2'h3);
    for (i = 0; i < 60; i++) op(xs() & 1, at[xs() % 8], xs(), xs());
    for (i = 0; i < 4; i++) op(0, at[1], 0, i);
    $display("random access test done");
    supply_good = 0;
    @(negedge clock);
    supply_good = 1;
    repeat (3) @(negedge clock);
    `CHK("ready_after_drop", 1'b0, req_ready)
    op(0, at[0], 0, 2'h3);
    $display("supply drop test done");
    retention_req = 1;
    for (k = 0; retention_ready !== 1'b1 && k < 10; k++) @(negedge clock);
    `CHK("ret_ready", 1'b1, retention_ready)
    `CHK("ret_cs_n", 1'b1, pins.chip_select_n)
    retention_req = 0;
    for (k = 0; req_ready !== 1'b1 && k < 10; k++) @(negedge clock);
    `CHK("recover", 1'b1, k >= READ_CYCLE_CYC && k < 10)
    op(0, at[1], 0, 2'h3);
    $display("retention test done");
    results;
  end
endmodule
